// ---- fpfm_pkg.sv ----
package fpfm_pkg;

   // ------------------------------------------------------------
   // Frame geometry
   // ------------------------------------------------------------
   localparam int CORE_FRAME_BYTES = 144;
   localparam int FRAME_PERIOD_US = 500;
   localparam int BLOCKS_PER_CORE = 4;
   localparam int BLOCK_BYTES = CORE_FRAME_BYTES / BLOCKS_PER_CORE;
   localparam int APP_SLOTS = 32;

   // ------------------------------------------------------------
   // Slot and core byte positions, one-pair of two-pair
   // ------------------------------------------------------------
   localparam logic [4:0] SLOT_ALIGN = 5'h00;
   localparam logic [4:0] SLOT_SIGNALLING = 5'h10;
   localparam logic [4:0] SLOT_LAST = 5'h1f;
   localparam logic [5:0] POS_ALIGN = 6'h00;
   localparam logic [5:0] POS_FIRST_USER = 6'h02;
   localparam logic [5:0] POS_LAST_LOW = 6'h10;
   localparam logic [5:0] POS_SIGNALLING = 6'h11;
   localparam logic [5:0] POS_FIRST_HIGH = 6'h13;
   localparam logic [5:0] POS_LAST_HIGH = 6'h21;
   localparam logic [5:0] POS_BLOCK_END = 6'h23;
   localparam logic [5:0] OFFSET_LOW = 6'h01;
   localparam logic [5:0] OFFSET_HIGH = 6'h02;

   // Core bytes emitted per application slot
   localparam logic [1:0] REPEAT_ONE = 2'h1;
   localparam logic [1:0] REPEAT_TWO = 2'h2;
   localparam logic [1:0] REPEAT_TAIL = 2'h3;

   // ------------------------------------------------------------
   // Patterns
   // ------------------------------------------------------------
   localparam logic [7:0] ALL_ONES = 8'hff;
   localparam logic [7:0] AUX_PATTERN_DEFAULT = 8'h55;

endpackage

// ---- fpfm_skid_buffer.sv ----
`timescale 1ns/1ps
`default_nettype none

module fpfm_skid_buffer #(
   parameter int WIDTH = 9
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   logic [WIDTH-1:0] tail_data;
   logic tail_valid;
   logic push;
   logic pop;
   logic next_tail_valid;

   // Handshakes; a push only happens while the tail is free
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Tail fills only when head is held and a new word arrives
   always_comb
   begin
      next_tail_valid = tail_valid;
      if (pop && tail_valid)
         next_tail_valid = 1'b0;
      else if (!pop && push && out_valid)
         next_tail_valid = 1'b1;
   end

   // Head entry drives the output directly from flops
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_valid <= 1'b0;
         out_data <= '0;
      end
      else if (pop && tail_valid)
      begin
         out_data <= tail_data;
      end
      else if (pop || !out_valid)
      begin
         out_valid <= push;
         if (push)
            out_data <= in_data;
      end
   end

   // Tail entry and registered ready
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tail_valid <= 1'b0;
         tail_data <= '0;
         in_ready <= 1'b0;
      end
      else
      begin
         tail_valid <= next_tail_valid;
         in_ready <= ~next_tail_valid;
         if (!pop && push && out_valid)
            tail_data <= in_data;
      end
   end

endmodule

`default_nettype wire

// ---- fpfm_mapper.sv ----
// Functional notes
// - Core bytes reach the pair as in any mapping; slot placement alone sets the layout.
// - Pairs with only all-ones stay undriven; the receiver rebuilds all-ones in their slots.
// - Rebuilt all-ones slots are exactly 8'hff, so the frame check downstream sees no errors.
// - System is up only when all installed pairs are active, ids correct and nothing failed.
// - Any installed pair not active or with a wrong id makes the whole system non-operational.
// - At the network end the output is flagged undefined while not fully operational.
// - At the line end any signal or alignment loss swaps output for all-ones or aux pattern.
// - At the line end a loopback request from the application side loops every installed pair transceiver.
// - The loop is closed right at the line port so it passes through the whole mapper datapath.
// - Core bytes 17 and 18 carry signalling, odd bytes 19 to 35 and byte 34 all-ones, even ones 20 to 32 user slots.
// - User, alignment and signalling slots carry traffic while every other mapped position carries all-ones.
// - The core frame is 144 bytes long, four blocks of 36 bytes, over 500 us.
`timescale 1ns/1ps
`default_nettype none

module fpfm_mapper #(
   parameter int N_PAIRS = 2,
   parameter logic [7:0] AUX_PATTERN = fpfm_pkg::AUX_PATTERN_DEFAULT
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Application transmit slots
   input wire logic app_tx_valid,
   output logic app_tx_ready,
   input wire logic [7:0] app_tx_data,
   input wire logic app_tx_sof,
   // Application receive slots
   output logic app_rx_valid,
   input wire logic app_rx_ready,
   output logic [7:0] app_rx_data,
   output logic app_rx_sof,
   output logic app_rx_undefined,
   // Line pair 1 transmit core bytes
   output logic line_tx_valid,
   input wire logic line_tx_ready,
   output logic [7:0] line_tx_data,
   output logic line_tx_sof,
   // Line pair 1 receive core bytes
   input wire logic line_rx_valid,
   output logic line_rx_ready,
   input wire logic [7:0] line_rx_data,
   input wire logic line_rx_sof,
   // Pair transceiver status and control
   input wire logic [N_PAIRS-1:0] pair_active,
   input wire logic [N_PAIRS-1:0] pair_id_ok,
   input wire logic other_failure,
   input wire logic [3:0] signal_loss,
   input wire logic [3:0] frame_alignment_loss,
   input wire logic loopback1_req,
   output logic [N_PAIRS-1:0] pair_loopback,
   output logic system_operational,
   // Configuration pins
   input wire logic [N_PAIRS-1:0] pair_installed_pin,
   input wire logic line_terminating_unit_pin,
   input wire logic aux_select_pin
);

   // ------------------------------------------------------------
   // Configuration pin synchronisers
   // ------------------------------------------------------------
   localparam int CFG_W = N_PAIRS + 2;
   logic [CFG_W-1:0] cfg_meta;
   logic [CFG_W-1:0] cfg_sync;
   logic [N_PAIRS-1:0] pair_installed;
   logic line_terminating_unit;
   logic aux_select;

   // Two stages; only the second stage feeds logic
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_meta <= '0;
         cfg_sync <= '0;
      end
      else
      begin
         cfg_meta <= {aux_select_pin, line_terminating_unit_pin, pair_installed_pin};
         cfg_sync <= cfg_meta;
      end
   end

   assign pair_installed = cfg_sync[N_PAIRS-1:0];
   assign line_terminating_unit = cfg_sync[N_PAIRS];
   assign aux_select = cfg_sync[N_PAIRS+1];

   // ------------------------------------------------------------
   // Slot classification
   // ------------------------------------------------------------
   // Odd slots below the signalling slot and even ones above carry traffic
   function automatic logic is_user(input logic [4:0] slot);
      logic lo;
      logic hi;
      lo = (slot < fpfm_pkg::SLOT_SIGNALLING) && slot[0];
      hi = (slot > fpfm_pkg::SLOT_SIGNALLING) && !slot[0];
      is_user = lo || hi || (slot == fpfm_pkg::SLOT_ALIGN)
         || (slot == fpfm_pkg::SLOT_SIGNALLING);
   endfunction

   // Core bytes spent on each slot: 36 per block in total
   function automatic logic [1:0] repeat_of(input logic [4:0] slot);
      if (slot == fpfm_pkg::SLOT_ALIGN || slot == fpfm_pkg::SLOT_SIGNALLING)
         repeat_of = fpfm_pkg::REPEAT_TWO;
      else if (slot == fpfm_pkg::SLOT_LAST)
         repeat_of = fpfm_pkg::REPEAT_TAIL;
      else
         repeat_of = fpfm_pkg::REPEAT_ONE;
   endfunction

   // ------------------------------------------------------------
   // Maintenance evaluation
   // ------------------------------------------------------------
   logic pairs_good;
   logic loss_any;
   logic loopback_on;

   assign pairs_good = &(~pair_installed | (pair_active & pair_id_ok));
   assign loss_any = (|signal_loss) | (|frame_alignment_loss);
   assign loopback_on = |pair_loopback;

   // Registered status outputs
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         system_operational <= 1'b0;
         app_rx_undefined <= 1'b1;
         pair_loopback <= '0;
      end
      else
      begin
         system_operational <= pairs_good && !other_failure && (|pair_installed);
         // Network end output has no meaning until fully up
         app_rx_undefined <= !line_terminating_unit
            && !(pairs_good && !other_failure && (|pair_installed));
         pair_loopback <= (line_terminating_unit && loopback1_req)
            ? pair_installed : '0;
      end
   end

   // ------------------------------------------------------------
   // Transmit mapping, application slots to core bytes
   // ------------------------------------------------------------
   logic [1:0] tx_rem;
   logic [4:0] tx_slot;
   logic [1:0] tx_blk;
   logic [4:0] slot_eff;
   logic tx_accept;
   logic tx_adv;
   logic rx_buf_ready;
   logic [1:0] next_tx_rem;

   assign slot_eff = app_tx_sof ? fpfm_pkg::SLOT_ALIGN : tx_slot;
   assign tx_accept = app_tx_valid && app_tx_ready;
   // In loopback the receive buffer may stall the line side too
   assign tx_adv = line_tx_valid && line_tx_ready && (!loopback_on || rx_buf_ready);

   // Remaining core bytes of the slot now presented
   always_comb
   begin
      next_tx_rem = tx_rem;
      if (tx_adv)
         next_tx_rem = tx_rem - fpfm_pkg::REPEAT_ONE;
      if (tx_accept)
         next_tx_rem = repeat_of(slot_eff);
   end

   // One idle cycle per slot keeps ready a plain flop; line rate is far below clock
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_rem <= '0;
         app_tx_ready <= 1'b0;
         line_tx_valid <= 1'b0;
      end
      else
      begin
         tx_rem <= next_tx_rem;
         app_tx_ready <= (next_tx_rem == '0);
         line_tx_valid <= (next_tx_rem != '0);
      end
   end

   // Core byte content; bytes go to pair 1 unchanged, pair 2 is not equipped
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_slot <= fpfm_pkg::SLOT_ALIGN;
         tx_blk <= '0;
         line_tx_data <= fpfm_pkg::ALL_ONES;
         line_tx_sof <= 1'b0;
      end
      else if (tx_accept)
      begin
         tx_slot <= slot_eff + 5'h01;
         line_tx_data <= is_user(slot_eff) ? app_tx_data : fpfm_pkg::ALL_ONES;
         line_tx_sof <= (slot_eff == fpfm_pkg::SLOT_ALIGN) && (tx_blk == '0);
         if (slot_eff == fpfm_pkg::SLOT_ALIGN)
            tx_blk <= tx_blk + 2'h1;
      end
      else if (tx_adv)
      begin
         line_tx_sof <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Receive demapping, core bytes to application slots
   // ------------------------------------------------------------
   logic rx_in_valid;
   logic [7:0] rx_in_data;
   logic rx_in_sof;
   logic [5:0] rx_pos;
   logic [5:0] pos_eff;
   logic rx_take;
   logic rx_emit;
   logic [4:0] rx_slot;
   logic [7:0] rx_mapped;
   logic [7:0] rx_word;
   logic [8:0] buf_in;
   logic [8:0] buf_out;

   // Loop closed at the line port, after every mapping stage
   assign rx_in_valid = loopback_on ? line_tx_valid && line_tx_ready : line_rx_valid;
   assign rx_in_data = loopback_on ? line_tx_data : line_rx_data;
   assign rx_in_sof = loopback_on ? line_tx_sof : line_rx_sof;
   assign line_rx_ready = rx_buf_ready;

   assign pos_eff = rx_in_sof ? fpfm_pkg::POS_ALIGN : rx_pos;
   assign rx_take = rx_in_valid && rx_buf_ready;

   // Position to slot: second alignment, second signalling and last two tail bytes yield nothing
   always_comb
   begin
      rx_emit = 1'b0;
      rx_slot = fpfm_pkg::SLOT_ALIGN;
      if (pos_eff == fpfm_pkg::POS_ALIGN)
      begin
         rx_emit = 1'b1;
      end
      else if (pos_eff >= fpfm_pkg::POS_FIRST_USER && pos_eff <= fpfm_pkg::POS_LAST_LOW)
      begin
         rx_emit = 1'b1;
         rx_slot = 5'(pos_eff - fpfm_pkg::OFFSET_LOW);
      end
      else if (pos_eff == fpfm_pkg::POS_SIGNALLING)
      begin
         rx_emit = 1'b1;
         rx_slot = fpfm_pkg::SLOT_SIGNALLING;
      end
      else if (pos_eff >= fpfm_pkg::POS_FIRST_HIGH && pos_eff <= fpfm_pkg::POS_LAST_HIGH)
      begin
         rx_emit = 1'b1;
         rx_slot = 5'(pos_eff - fpfm_pkg::OFFSET_HIGH);
      end
   end

   // Dropped slots rebuilt as exact all-ones, whatever the line held
   assign rx_mapped = is_user(rx_slot) ? rx_in_data : fpfm_pkg::ALL_ONES;
   // Line end masks traffic on any loss; pattern chosen by the operator pin
   assign rx_word = (line_terminating_unit && loss_any)
      ? (aux_select ? AUX_PATTERN : fpfm_pkg::ALL_ONES) : rx_mapped;
   assign buf_in = {(rx_slot == fpfm_pkg::SLOT_ALIGN), rx_word};

   // Block position tracking, realigned by each start marker
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         rx_pos <= fpfm_pkg::POS_ALIGN;
      else if (rx_take)
         rx_pos <= (pos_eff == fpfm_pkg::POS_BLOCK_END)
            ? fpfm_pkg::POS_ALIGN : pos_eff + 6'h01;
   end

   // Two-entry buffer so a stalled application loses no slot
   fpfm_skid_buffer #(
      .WIDTH(9)
   ) u_rx_buf (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .in_valid(rx_take && rx_emit),
      .in_ready(rx_buf_ready),
      .in_data(buf_in),
      .out_valid(app_rx_valid),
      .out_ready(app_rx_ready),
      .out_data(buf_out)
   );

   assign app_rx_data = buf_out[7:0];
   assign app_rx_sof = buf_out[8];

endmodule

`default_nettype wire

// ---- fpfm_mapper_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpfm_mapper_props #(
   parameter int N_PAIRS = 2,
   parameter logic [7:0] AUX_PATTERN = fpfm_pkg::AUX_PATTERN_DEFAULT
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Slot and core byte streams
   input wire logic app_tx_valid,
   input wire logic app_tx_ready,
   input wire logic app_rx_valid,
   input wire logic app_rx_ready,
   input wire logic [7:0] app_rx_data,
   input wire logic app_rx_undefined,
   input wire logic line_tx_valid,
   input wire logic line_tx_ready,
   input wire logic [7:0] line_tx_data,
   // Status, control and pins
   input wire logic [N_PAIRS-1:0] pair_active,
   input wire logic [N_PAIRS-1:0] pair_id_ok,
   input wire logic other_failure,
   input wire logic [3:0] signal_loss,
   input wire logic [3:0] frame_alignment_loss,
   input wire logic loopback1_req,
   input wire logic [N_PAIRS-1:0] pair_loopback,
   input wire logic system_operational,
   input wire logic [N_PAIRS-1:0] pair_installed_pin,
   input wire logic line_terminating_unit_pin,
   input wire logic aux_select_pin
);
   logic [N_PAIRS+9:0] cfg_q;
   logic [3:0] q_cnt;
   wire logic [N_PAIRS+9:0] cfg = {pair_installed_pin, line_terminating_unit_pin,
      aux_select_pin, signal_loss, frame_alignment_loss};
   wire logic bad_pair = |(pair_installed_pin & ~(pair_active & pair_id_ok));
   wire logic lossy = |{signal_loss, frame_alignment_loss};
   // Quiet time of pins and loss; pins cross a two-flop sync first
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_q <= '0;
         q_cnt <= 4'h0;
      end
      else
      begin
         cfg_q <= cfg;
         if (cfg != cfg_q)
            q_cnt <= 4'h0;
         else if (q_cnt != 4'hf)
            q_cnt <= q_cnt + 4'h1;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_slot_taken;
      app_tx_valid && app_tx_ready;
   endsequence
   sequence s_net_down;
      (q_cnt > 4'h4 && !line_terminating_unit_pin && !system_operational) [*2];
   endsequence
   a_tx_answer: assert property (s_slot_taken |=> line_tx_valid && !app_tx_ready)
      else $error("no core byte after slot");
   a_tx_hold: assert property (line_tx_valid && !line_tx_ready
      |=> line_tx_valid && $stable(line_tx_data)) else $error("core byte dropped");
   a_rx_hold: assert property (app_rx_valid && !app_rx_ready
      |=> app_rx_valid && $stable(app_rx_data)) else $error("slot byte dropped");
   a_status_ok: assert property (q_cnt > 4'h4 && pair_installed_pin != '0 && !bad_pair
      && !other_failure |=> system_operational) else $error("not operational");
   a_status_bad: assert property (other_failure || (q_cnt > 4'h4 && bad_pair)
      |=> !system_operational) else $error("operational in failure");
   a_undef_net: assert property (s_net_down |-> app_rx_undefined)
      else $error("undefined flag low");
   a_loop_pairs: assert property (q_cnt > 4'h4 && line_terminating_unit_pin
      && loopback1_req |=> pair_loopback == $past(pair_installed_pin))
      else $error("loopback pairs wrong");
   a_loss_fill: assert property (q_cnt == 4'hf && line_terminating_unit_pin && lossy
      && app_rx_valid |-> app_rx_data == (aux_select_pin ? AUX_PATTERN : 8'hff))
      else $error("loss fill wrong");
endmodule
bind fpfm_mapper fpfm_mapper_props #(.N_PAIRS(N_PAIRS), .AUX_PATTERN(AUX_PATTERN)) u_props (.*);
`default_nettype wire

// ---- fpfm_line_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpfm_line_model (
   // Clock
   input wire logic core_clk,
   // Core bytes towards the pair
   input wire logic line_tx_valid,
   output logic line_tx_ready,
   input wire logic [7:0] line_tx_data,
   input wire logic line_tx_sof,
   // Core bytes from the pair
   output logic line_rx_valid,
   input wire logic line_rx_ready,
   output logic [7:0] line_rx_data,
   output logic line_rx_sof
);
   logic [8:0] tx_q[$];
   logic [8:0] rx_q[$];
   logic [1:0] beat = 2'h0;
   logic took = 1'b0;
   // Idle after power-up
   initial
   begin
      line_tx_ready = 1'b0;
      line_rx_valid = 1'b0;
      line_rx_data = 8'h00;
      line_rx_sof = 1'b0;
   end
   // Handshakes complete on the rising edge
   always @(posedge core_clk)
   begin
      if (line_tx_valid && line_tx_ready)
         tx_q.push_back({line_tx_sof, line_tx_data});
      took <= line_rx_valid && line_rx_ready;
   end
   // Stall one beat in four; idle data toggles so no stale byte reads as valid
   always @(negedge core_clk)
   begin
      beat <= beat + 2'h1;
      line_tx_ready <= beat != 2'h3;
      if (took || !line_rx_valid)
      begin
         line_rx_valid <= rx_q.size() > 0;
         if (rx_q.size() > 0)
            {line_rx_sof, line_rx_data} <= rx_q.pop_front();
         else
            line_rx_data <= ~line_rx_data;
      end
   end
endmodule
`default_nettype wire

// ---- fractional_pair_frame_mapper_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module fractional_pair_frame_mapper_tb_top;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic app_tx_valid = 1'b0, app_tx_sof = 1'b0, app_rx_ready = 1'b1;
   logic [7:0] app_tx_data = 8'h00;
   logic other_failure = 1'b0, loopback1_req = 1'b0;
   logic line_terminating_unit_pin = 1'b0, aux_select_pin = 1'b0;
   logic [1:0] pair_active = 2'h3, pair_id_ok = 2'h3, pair_installed_pin = 2'h3;
   logic [3:0] signal_loss = 4'h0, frame_alignment_loss = 4'h0;
   logic app_tx_ready, app_rx_valid, app_rx_sof, app_rx_undefined, system_operational;
   logic line_tx_valid, line_tx_ready, line_tx_sof, line_rx_valid, line_rx_ready, line_rx_sof;
   logic [7:0] app_rx_data, line_tx_data, line_rx_data;
   logic [1:0] pair_loopback;
   logic [8:0] rq[$];
   int n_errors = 0, checks_done = 0, cyc = 0;
   fpfm_mapper u_dut (.*);
   fpfm_line_model u_line (.*);
   // Clock
   initial
   begin
      forever #5 core_clk = ~core_clk;
   end
   // Catch delivered slots; cut a hang short
   always @(posedge core_clk)
   begin
      cyc++;
      if (app_rx_valid && app_rx_ready)
         rq.push_back({app_rx_sof, app_rx_data});
      if (cyc == 20000)
      begin
         n_errors++;
         $display("wrong value at %0t: hung", $time);
         end_of_test();
      end
   end
   // Filler slots travel as all-ones
   function automatic logic [7:0] slot_val(input int ts, input logic [7:0] d);
      return (ts == 0 || ts == 16 || (ts < 16) == ts[0]) ? d : 8'hff;
   endfunction
   task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string m);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: %s %h not %h", $time, m, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic send_frame();
      for (int ts = 0; ts < 32; ts++)
      begin
         app_tx_valid = 1'b1;
         app_tx_data = 8'(ts) + 8'ha0;
         app_tx_sof = ts == 0;
         while (!app_tx_ready)
            @(negedge core_clk);
         @(negedge core_clk);
      end
   endtask
   task automatic push_block();
      for (int p = 0; p < 36; p++)
         u_line.rx_q.push_back({p == 0, 8'(p) + 8'h40});
   endtask
   // Mode 0 line bytes, 1 looped slots, 2 forced fill
   task automatic rx_check(input int mode, input logic [7:0] v);
      logic [7:0] e;
      for (int k = 0; k < 3000 && rq.size() < 32; k++)
         @(negedge core_clk);
      chk(9'(rq.size()), 9'h020, "slots");
      for (int ts = 0; ts < 32; ts++)
      begin
         e = 8'(ts == 0 ? 0 : ts < 17 ? ts + 1 : ts + 2) + 8'h40;
         e = mode == 2 ? v : slot_val(ts, mode == 1 ? 8'(ts) + 8'ha0 : e);
         chk(rq.pop_front(), {ts == 0, e}, "slot");
      end
   endtask
   task automatic t_tx_map();
      int q;
      logic [7:0] e;
      repeat (4)
         send_frame();
      app_tx_valid = 1'b0;
      repeat (20)
         @(negedge core_clk);
      chk(9'(u_line.tx_q.size()), 9'h090, "core count");
      for (int p = 0; p < 144; p++)
      begin
         q = p % 36;
         q = q < 2 ? 0 : q < 17 ? q - 1 : q < 19 ? 16 : q < 34 ? q - 2 : 31;
         e = slot_val(q, 8'(q) + 8'ha0);
         chk(u_line.tx_q.pop_front(), {p == 0, e}, "core");
      end
      $display("tx mapping done");
   endtask
   task automatic t_rx_map();
      app_rx_ready = 1'b0;
      push_block();
      repeat (12)
         @(negedge core_clk);
      chk({7'h00, app_rx_valid, line_rx_ready}, 9'h002, "full");
      app_rx_ready = 1'b1;
      rx_check(0, 8'h00);
      $display("rx mapping done");
   endtask
   task automatic t_status();
      logic ok;
      for (int k = 0; k < 128; k++)
      begin
         {pair_installed_pin, pair_active, pair_id_ok, other_failure} = k[6:0];
         repeat (5)
            @(negedge core_clk);
         ok = pair_installed_pin != 2'h0 && !other_failure
            && (pair_installed_pin & ~(pair_active & pair_id_ok)) == 2'h0;
         chk({8'h00, system_operational}, {8'h00, ok}, "operational");
         chk({8'h00, app_rx_undefined}, {8'h00, !ok}, "undefined");
      end
      {pair_installed_pin, pair_active, pair_id_ok, other_failure} = 7'h7e;
      $display("status done");
   endtask
   task automatic t_loss();
      line_terminating_unit_pin = 1'b1;
      for (int k = 0; k < 8; k++)
      begin
         aux_select_pin = k[0];
         {frame_alignment_loss, signal_loss} = 8'h01 << k;
         repeat (20)
            @(negedge core_clk);
         push_block();
         rx_check(2, k[0] ? fpfm_pkg::AUX_PATTERN_DEFAULT : 8'hff);
      end
      {frame_alignment_loss, signal_loss} = 8'h00;
      $display("loss done");
   endtask
   task automatic t_loop();
      loopback1_req = 1'b1;
      repeat (3)
         @(negedge core_clk);
      chk({7'h00, pair_loopback}, {7'h00, pair_installed_pin}, "loop");
      send_frame();
      app_tx_valid = 1'b0;
      rx_check(1, 8'h00);
      loopback1_req = 1'b0;
      $display("loopback done");
   endtask
   // Main sequence
   initial
   begin
      repeat (6)
         @(negedge core_clk);
      rst_n = 1'b1;
      repeat (4)
         @(negedge core_clk);
      t_tx_map();
      t_rx_map();
      t_status();
      t_loss();
      t_loop();
      end_of_test();
   end
endmodule
`default_nettype wire
